//--- hw/tick_and_watchdog_timers.sv
// periodic tick timer and windowed watchdog with their control registers
//
// What this block does
// - watchdog source: RC, oscillator, or autonomous clock
// - tick source select; runs in stop conditionally
// - tick control write or source change restarts
// - bit 7 selects binary or decimal divide
// - binary: prescale 000 off, else 2^10..2^16
// - decimal: prescale picks 1k to 200k
// - tick timer resets off, all zero
// - watchdog source change or oscillator loss restarts
// - watchdog stop-mode running conditions
// - window and rate loaded from flash; nonzero starts
// - window/rate write-once in normal, mask zero
// - debug-halt bit set-only (sticky) in normal mode
// - normal-mode restart conditions for watchdog
// - special mode: every control write restarts
// - write mask blocks window/rate, no once count
// - window mode: refresh only in last quarter
// - debug-halt bit freezes counters in debug
// - nonzero rate enables; expiry requests system reset
// - special debug override: longest, non-window period
// - normal-source timeout table 2^14..2^24
// - autonomous clock halved; table 2^7..2^17
// - two-key refresh; bad value resets; reads zero
// - tick interrupt when flag and enable set
`timescale 1ns/1ps

module tick_and_watchdog_timers (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic irc_tick,
  input wire logic osc_tick,
  input wire logic aclk_tick,
  input wire logic osc_qualified,
  input wire logic stop_mode,
  input wire logic debug_active,
  input wire logic special_mode,
  input wire logic flash_load,
  input wire logic flash_window,
  input wire logic [2:0] flash_rate,
  output logic tick_irq,
  output logic wdog_reset_req
);

  // ****************************************
  // control registers
  // ****************************************
  logic tick_flag;
  logic tick_irq_enable;
  logic pseudo_stop_select;
  logic wdog_aclk_select;
  logic wdog_run_in_pseudo_stop;
  logic tick_osc_select;
  logic wdog_osc_select;
  logic [7:0] tick_ctrl;
  logic window_mode_bit;
  logic debug_halt_counters;
  logic [2:0] wdog_rate_field;
  logic once_done;
  logic osc_qualified_d;
  tick_wdog_pkg::refresh_state_t key_state;

  // ****************************************
  // bus decode
  // ****************************************
  wire wr_status = wr_stb && (addr == tick_wdog_pkg::OFS_TICK_STATUS);
  wire wr_irq_en = wr_stb && (addr == tick_wdog_pkg::OFS_IRQ_ENABLE);
  wire wr_clksel = wr_stb && (addr == tick_wdog_pkg::OFS_CLOCK_SELECT);
  wire wr_tick = wr_stb && (addr == tick_wdog_pkg::OFS_TICK_RATE_CONTROL);
  wire wr_wdog = wr_stb && (addr == tick_wdog_pkg::OFS_WATCHDOG_CONTROL);
  wire wr_refresh = wr_stb && (addr == tick_wdog_pkg::OFS_WDOG_REFRESH);

  // oscillator loss: falling edge of the qualified status
  wire osc_lost = osc_qualified_d && !osc_qualified;

  // oscillator selects may only be set while the oscillator is qualified
  wire new_tick_osc = wr_data[tick_wdog_pkg::BIT_TICK_OSC_SELECT] && osc_qualified;
  wire new_wdog_osc = wr_data[tick_wdog_pkg::BIT_WDOG_OSC_SELECT] && osc_qualified;
  wire new_aclk = wr_data[tick_wdog_pkg::BIT_WDOG_ACLK_SELECT];

  // ****************************************
  // tick timer control
  // ****************************************
  wire tick_src_change = (wr_clksel && (new_tick_osc != tick_osc_select))
                         || (osc_lost && tick_osc_select);
  wire tick_restart = wr_tick || tick_src_change;

  wire tick_decimal_select = tick_ctrl[tick_wdog_pkg::BIT_TICK_DECIMAL];
  wire [2:0] tick_prescale = tick_ctrl[6:4];
  wire [3:0] tick_modulus = tick_ctrl[3:0];
  wire tick_off = !tick_decimal_select && (tick_prescale == 3'h0);

  // base divide: binary 2^(9+n) or decimal table entry
  wire [4:0] bin_exp = 5'(tick_wdog_pkg::TICK_BIN_EXP_BASE) + {2'h0, tick_prescale};
  wire [21:0] bin_base = 22'h000001 << bin_exp;
  wire [21:0] dec_base = tick_wdog_pkg::TICK_DEC_BASE[tick_prescale];
  wire [21:0] tick_base = tick_decimal_select ? dec_base : bin_base;
  wire [26:0] tick_period_full = tick_base * ({1'b0, tick_modulus} + 5'h01);
  wire [23:0] tick_period = tick_period_full[23:0];

  // source pulse and gating for stop and debug
  wire tick_src_pulse = tick_osc_select ? osc_tick : irc_tick;
  wire tick_stop_ok = !stop_mode || (pseudo_stop_select && tick_osc_select);
  wire dbg_freeze = debug_active && debug_halt_counters;
  wire tick_advance = tick_src_pulse && tick_stop_ok && !dbg_freeze && !tick_off;

  logic [23:0] tick_count;
  wire tick_expire = tick_advance && (tick_count == tick_period - 24'h000001);

  // ****************************************
  // watchdog control writes
  // ****************************************
  wire wr_mask = wr_data[tick_wdog_pkg::BIT_WRITE_MASK];
  wire wr_window = wr_data[tick_wdog_pkg::BIT_WINDOW_MODE];
  wire [2:0] wr_rate = wr_data[2:0];
  wire wr_halt = wr_data[tick_wdog_pkg::BIT_DEBUG_HALT];

  // a masked write changes neither window nor rate and does not use up the single write
  wire ctrl_accept = wr_wdog && !wr_mask && (special_mode || !once_done);
  wire rate_take = ctrl_accept && (wr_rate != tick_wdog_pkg::WDOG_RATE_OFF);
  wire window_take = ctrl_accept && wr_window;
  wire halt_rise = wr_wdog && wr_halt && !debug_halt_counters;

  wire wdog_src_change = (wr_clksel && (new_aclk != wdog_aclk_select))
                         || (wr_clksel && !wdog_aclk_select && (new_wdog_osc != wdog_osc_select))
                         || (osc_lost && !wdog_aclk_select && wdog_osc_select);

  // ****************************************
  // watchdog timing
  // ****************************************
  wire wdog_enabled = (wdog_rate_field != tick_wdog_pkg::WDOG_RATE_OFF);
  wire dbg_override = wdog_enabled && debug_active && !debug_halt_counters && special_mode;
  wire [4:0] rate_exp = wdog_aclk_select ? tick_wdog_pkg::WDOG_EXP_ACLK[wdog_rate_field]
                                         : tick_wdog_pkg::WDOG_EXP_NORMAL[wdog_rate_field];
  wire [4:0] wdog_exp = dbg_override ? tick_wdog_pkg::WDOG_EXP_LONGEST : rate_exp;
  wire [24:0] wdog_period = 25'h0000001 << wdog_exp;
  wire [24:0] window_open = wdog_period - (wdog_period >> 2);
  wire window_active = window_mode_bit && !dbg_override;

  // autonomous clock halved by a toggle before it reaches the counter
  logic aclk_half;
  wire wdog_src_pulse = wdog_aclk_select ? (aclk_tick && aclk_half)
                                         : (wdog_osc_select ? osc_tick : irc_tick);
  wire wdog_stop_ok = !stop_mode || wdog_aclk_select
                      || (pseudo_stop_select && wdog_osc_select && wdog_run_in_pseudo_stop);
  wire wdog_advance = wdog_enabled && wdog_src_pulse && wdog_stop_ok && !dbg_freeze;

  logic [24:0] wdog_count;
  wire wdog_expire = wdog_advance && (wdog_count == wdog_period - 25'h0000001);

  // refresh sequence checks
  wire key_is_first = (wr_data == tick_wdog_pkg::KEY_FIRST);
  wire key_is_second = (wr_data == tick_wdog_pkg::KEY_SECOND);
  wire refresh_live = wr_refresh && wdog_enabled;
  wire too_early = window_active && (wdog_count < window_open);
  wire refresh_bad = refresh_live && (!(key_is_first || key_is_second) || too_early);
  wire refresh_done = refresh_live && !refresh_bad && key_is_second
                      && (key_state == tick_wdog_pkg::key_armed);

  // normal mode restarts only on effective writes; special mode on any write
  wire wdog_ctrl_restart = special_mode ? wr_wdog : (rate_take || window_take || halt_rise);
  wire flash_restart = flash_load && (flash_rate != tick_wdog_pkg::WDOG_RATE_OFF);
  wire wdog_restart = wdog_ctrl_restart || wdog_src_change || flash_restart || refresh_done;

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] rd_status = {tick_flag, 7'h00};
  wire [7:0] rd_irq_en = {tick_irq_enable, 7'h00};
  wire [7:0] rd_clksel = {1'b0, pseudo_stop_select, 1'b0, wdog_aclk_select, 1'b0,
                          wdog_run_in_pseudo_stop, tick_osc_select, wdog_osc_select};
  wire [7:0] rd_wdog = {window_mode_bit, debug_halt_counters, 3'h0, wdog_rate_field};
  wire [7:0] next_rd_data = (addr == tick_wdog_pkg::OFS_TICK_STATUS) ? rd_status :
                            (addr == tick_wdog_pkg::OFS_IRQ_ENABLE) ? rd_irq_en :
                            (addr == tick_wdog_pkg::OFS_CLOCK_SELECT) ? rd_clksel :
                            (addr == tick_wdog_pkg::OFS_TICK_RATE_CONTROL) ? tick_ctrl :
                            (addr == tick_wdog_pkg::OFS_WATCHDOG_CONTROL) ? rd_wdog :
                            8'h00; // refresh register and unmapped read zero

  // ****************************************
  // processes
  // ****************************************

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_stb ? next_rd_data : 8'h00;
    end
  end

  // tick interrupt registered so the output comes from a flop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_irq <= 1'b0;
    end else begin
      tick_irq <= tick_flag && tick_irq_enable;
    end
  end

  // interrupt enable and tick flag; a new tick wins over a clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_irq_enable <= 1'b0;
      tick_flag <= 1'b0;
    end else begin
      if (wr_irq_en) begin
        tick_irq_enable <= wr_data[tick_wdog_pkg::BIT_TICK_IRQ_ENABLE];
      end
      if (tick_expire) begin
        tick_flag <= 1'b1;
      end else if (wr_status && wr_data[tick_wdog_pkg::BIT_TICK_FLAG]) begin
        tick_flag <= 1'b0;
      end
    end
  end

  // clock select bits; losing the oscillator drops its selects
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pseudo_stop_select <= 1'b0;
      wdog_aclk_select <= 1'b0;
      wdog_run_in_pseudo_stop <= 1'b0;
      tick_osc_select <= 1'b0;
      wdog_osc_select <= 1'b0;
      osc_qualified_d <= 1'b0;
    end else begin
      osc_qualified_d <= osc_qualified;
      if (wr_clksel) begin
        pseudo_stop_select <= wr_data[tick_wdog_pkg::BIT_PSEUDO_STOP];
        wdog_aclk_select <= new_aclk;
        wdog_run_in_pseudo_stop <= wr_data[tick_wdog_pkg::BIT_WDOG_RUN_IN_PSTOP];
      end
      if (!osc_qualified) begin
        tick_osc_select <= 1'b0;
        wdog_osc_select <= 1'b0;
      end else if (wr_clksel) begin
        tick_osc_select <= new_tick_osc;
        wdog_osc_select <= new_wdog_osc;
      end
    end
  end

  // tick control comes out of reset with the timer off
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_ctrl <= tick_wdog_pkg::TICK_CTRL_RESET;
    end else if (wr_tick) begin
      tick_ctrl <= wr_data;
    end
  end

  // tick counter reloads itself at every period end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_count <= 24'h000000;
    end else if (tick_restart || tick_expire) begin
      tick_count <= 24'h000000;
    end else if (tick_advance) begin
      tick_count <= tick_count + 24'h000001;
    end
  end

  // watchdog control: flash load, write once, sticky debug-halt in normal mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      window_mode_bit <= 1'b0;
      debug_halt_counters <= 1'b0;
      wdog_rate_field <= tick_wdog_pkg::WDOG_RATE_OFF;
      once_done <= 1'b0;
    end else begin
      if (flash_load) begin
        window_mode_bit <= flash_window;
        wdog_rate_field <= flash_rate;
      end else begin
        if (window_take) begin
          window_mode_bit <= 1'b1;
        end
        if (rate_take) begin
          wdog_rate_field <= wr_rate;
        end
      end
      if (ctrl_accept) begin
        once_done <= 1'b1;
      end
      if (wr_wdog && (special_mode || wr_halt)) begin
        debug_halt_counters <= wr_halt;
      end
    end
  end

  // autonomous clock divider
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aclk_half <= 1'b0;
    end else if (aclk_tick) begin
      aclk_half <= !aclk_half;
    end
  end

  // watchdog counter; restarts on any restart cause
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdog_count <= 25'h0000000;
    end else if (wdog_restart) begin
      wdog_count <= 25'h0000000;
    end else if (wdog_advance && !wdog_expire) begin
      wdog_count <= wdog_count + 25'h0000001;
    end
  end

  // refresh key sequence; repeated first keys keep it armed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      key_state <= tick_wdog_pkg::key_idle;
    end else if (refresh_live) begin
      case (key_state)
        tick_wdog_pkg::key_idle: begin
          key_state <= key_is_first ? tick_wdog_pkg::key_armed : tick_wdog_pkg::key_idle;
        end
        tick_wdog_pkg::key_armed: begin
          key_state <= key_is_first ? tick_wdog_pkg::key_armed : tick_wdog_pkg::key_idle;
        end
        default: begin
          key_state <= tick_wdog_pkg::key_idle;
        end
      endcase
    end
  end

  // reset request holds until the system reset clears the block
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdog_reset_req <= 1'b0;
    end else if ((wdog_expire && !wdog_restart) || refresh_bad) begin
      wdog_reset_req <= 1'b1;
    end
  end

endmodule

//--- hw/tick_wdog_pkg.sv
// shared offsets, field positions, reset values and timing tables for the tick and watchdog block
package tick_wdog_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_TICK_STATUS = 8'h37;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h38;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h39;
  localparam logic [7:0] OFS_TICK_RATE_CONTROL = 8'h3B;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h3C;
  localparam logic [7:0] OFS_WDOG_REFRESH = 8'h3F;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_TICK_FLAG = 7;
  localparam int BIT_TICK_IRQ_ENABLE = 7;
  localparam int BIT_PSEUDO_STOP = 6;
  localparam int BIT_WDOG_ACLK_SELECT = 4;
  localparam int BIT_WDOG_RUN_IN_PSTOP = 2;
  localparam int BIT_TICK_OSC_SELECT = 1;
  localparam int BIT_WDOG_OSC_SELECT = 0;
  localparam int BIT_TICK_DECIMAL = 7;
  localparam int BIT_WINDOW_MODE = 7;
  localparam int BIT_DEBUG_HALT = 6;
  localparam int BIT_WRITE_MASK = 5;

  // ****************************************
  // reset values and keys
  // ****************************************
  localparam logic [7:0] TICK_CTRL_RESET = 8'h00;
  localparam logic [2:0] WDOG_RATE_OFF = 3'h0;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ****************************************
  // timing tables (counts of source clock cycles)
  // ****************************************
  localparam int TICK_BIN_EXP_BASE = 9;
  localparam logic [21:0] TICK_DEC_BASE [8] = '{22'h0003E8, 22'h0007D0, 22'h001388, 22'h002710,
                                                 22'h004E20, 22'h00C350, 22'h0186A0, 22'h030D40};
  localparam logic [4:0] WDOG_EXP_NORMAL [8] = '{5'h00, 5'h0E, 5'h10, 5'h12, 5'h14, 5'h16, 5'h17, 5'h18};
  localparam logic [4:0] WDOG_EXP_ACLK [8] = '{5'h00, 5'h07, 5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h10, 5'h11};
  localparam logic [4:0] WDOG_EXP_LONGEST = 5'h18;

  typedef enum logic {key_idle, key_armed} refresh_state_t;

endpackage

//--- tb/tick_and_watchdog_timers_checker.sv
// port-level assertions for the tick and watchdog block
`timescale 1ns/1ps

module tick_and_watchdog_timers_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic special_mode,
  input wire logic flash_load,
  input wire logic [2:0] flash_rate,
  input wire logic tick_irq,
  input wire logic wdog_reset_req
);
  logic [7:0] tick_ctrl;
  logic irq_en;
  logic wd_on;
  logic once_used;
  // ****************************************
  // bus decodes and shadow state
  // ****************************************
  wire rd_tick = rd_stb && addr == tick_wdog_pkg::OFS_TICK_RATE_CONTROL;
  wire rd_ctl = rd_stb && addr == tick_wdog_pkg::OFS_WATCHDOG_CONTROL;
  wire rd_ref = rd_stb && addr == tick_wdog_pkg::OFS_WDOG_REFRESH;
  wire wr_ctl = wr_stb && addr == tick_wdog_pkg::OFS_WATCHDOG_CONTROL && !wr_data[5] && (special_mode || !once_used);
  wire bad_key = wr_stb && addr == tick_wdog_pkg::OFS_WDOG_REFRESH && wr_data != 8'h55 && wr_data != 8'hAA;
  // once enabled the watchdog cannot be switched off short of reset or a flash load of rate zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_ctrl <= 8'h00;
      irq_en <= 1'b0;
      wd_on <= 1'b0;
      once_used <= 1'b0;
    end else begin
      if (wr_stb && addr == tick_wdog_pkg::OFS_TICK_RATE_CONTROL) tick_ctrl <= wr_data;
      if (wr_stb && addr == tick_wdog_pkg::OFS_IRQ_ENABLE) irq_en <= wr_data[7];
      if ((wr_ctl && wr_data[2:0] != 3'h0) || (flash_load && flash_rate != 3'h0)) wd_on <= 1'b1;
      if (wr_ctl && !special_mode) once_used <= 1'b1;
    end
  end

  reset_clears_a: assert property (@(posedge ref_clk)
    srst |=> !wdog_reset_req && !tick_irq && rd_data == 8'h00) else $error("outputs not cleared by reset");
  tick_readback_a: assert property (@(posedge ref_clk) disable iff (srst)
    $past(rd_tick) |-> rd_data == $past(tick_ctrl)) else $error("tick control readback wrong");
  mask_reads_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
    $past(rd_ctl) |-> rd_data[5:3] == 3'h0) else $error("write mask bit read back");
  refresh_reads_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
    $past(rd_ref) |-> rd_data == 8'h00) else $error("refresh register not zero");
  bad_key_a: assert property (@(posedge ref_clk) disable iff (srst)
    bad_key && wd_on |=> wdog_reset_req) else $error("bad key gave no reset request");
  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
    !wd_on && !wdog_reset_req |=> !wdog_reset_req) else $error("disabled watchdog fired");
  reset_req_held_a: assert property (@(posedge ref_clk) disable iff (srst)
    wdog_reset_req |=> wdog_reset_req) else $error("reset request dropped");
  irq_needs_en_a: assert property (@(posedge ref_clk) disable iff (srst)
    tick_irq |-> $past(irq_en)) else $error("tick interrupt while disabled");
endmodule

bind tick_and_watchdog_timers tick_and_watchdog_timers_checker chk (.ref_clk(ref_clk), .srst(srst), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .special_mode(special_mode),
  .flash_load(flash_load), .flash_rate(flash_rate), .tick_irq(tick_irq), .wdog_reset_req(wdog_reset_req));

//--- tb/tick_and_watchdog_timers_tb_top.sv
// self-checking testbench for the tick and watchdog block
`timescale 1ns/1ps

module tick_and_watchdog_timers_tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0, rd_stb = 1'b0, debug_active = 1'b0, special_mode = 1'b0;
  // rc and aclk ticks run every cycle so rc counts equal cycles, aclk counts take two; oscillator paths stay off until t_stop
  logic irc_tick = 1'b1, aclk_tick = 1'b1, osc_tick = 1'b0, osc_qualified = 1'b0, stop_mode = 1'b0;
  logic flash_load = 1'b0, flash_window = 1'b0;
  logic [2:0] flash_rate = 3'h0;
  logic [7:0] rd_data;
  logic tick_irq, wdog_reset_req;
  int n_fail = 0;
  int total_checks = 0;
  int n;

  always #25 ref_clk = ~ref_clk;

  tick_and_watchdog_timers dut (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .irc_tick(irc_tick), .osc_tick(osc_tick), .aclk_tick(aclk_tick),
    .osc_qualified(osc_qualified), .stop_mode(stop_mode), .debug_active(debug_active),
    .special_mode(special_mode), .flash_load(flash_load), .flash_window(flash_window),
    .flash_rate(flash_rate), .tick_irq(tick_irq), .wdog_reset_req(wdog_reset_req));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (exp !== got) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // idle cycle after each write keeps the strobe from being driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    check(what, exp, rd_data);
    @(posedge ref_clk);
  endtask

  task automatic req_is(input string what, input logic exp);
    #1;
    check(what, {7'h00, exp}, {7'h00, wdog_reset_req});
  endtask

  // counts cycles until tick_irq (sel 1) or wdog_reset_req rises; bounded so a dead counter cannot hang
  task automatic rise_in(input bit sel, input int lo, input int hi, input string what);
    n = 0;
    while (((sel ? tick_irq : wdog_reset_req) !== 1'b1) && n <= hi) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    total_checks++;
    if (n < lo || n > hi) begin
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, n);
      n_fail++;
    end
  endtask

  task automatic do_reset;
    srst <= 1'b1;
    special_mode <= 1'b0;
    debug_active <= 1'b0;
    cyc(6);
    srst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    do_reset;
    rd(8'h3B, 8'h00, "tick ctrl reset");
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00, "unmapped");
    wr(8'h3B, 8'hDA);
    rd(8'h3B, 8'hDA, "tick ctrl");
    wr(8'h3F, 8'h55);
    rd(8'h3F, 8'h00, "refresh read");
  endtask

  task automatic t_tick;
    logic [7:0] cfg [5] = '{8'h10, 8'h11, 8'h80, 8'h81, 8'h31};
    int per [5] = '{1024, 2048, 1000, 2000, 8192};
    do_reset;
    wr(8'h38, 8'h80);
    for (int i = 0; i < 5; i++) begin
      wr(8'h37, 8'h80);
      wr(8'h3B, cfg[i]);
      rise_in(1'b1, per[i] - 8, per[i] + 8, "tick period");
    end
    wr(8'h37, 8'h80);
    rise_in(1'b1, 8180, 8200, "tick reload");
    wr(8'h37, 8'h80);
    wr(8'h3B, 8'h00);
    cyc(1100);
    #1;
    check("tick off", 8'h00, {7'h00, tick_irq});
    wr(8'h38, 8'h00);
    wr(8'h3B, 8'h10);
    cyc(1100);
    #1;
    check("irq masked", 8'h00, {7'h00, tick_irq});
    wr(8'h38, 8'h80);
    rise_in(1'b1, 0, 2, "irq unmasked");
  endtask

  task automatic t_wdog;
    for (int r = 1; r < 3; r++) begin
      do_reset;
      wr(8'h39, 8'h10);
      wr(8'h3C, r[7:0]);
      rise_in(1'b0, (1 << (2 * r + 6)) - 6, (1 << (2 * r + 6)) + 6, "wdog aclk rate");
    end
    do_reset;
    wr(8'h39, 8'h10);
    wr(8'h3C, 8'h01);
    cyc(200);
    wr(8'h39, 8'h00);
    wr(8'h39, 8'h10);
    rise_in(1'b0, 250, 262, "source restart");
  endtask

  task automatic t_refresh;
    do_reset;
    wr(8'h39, 8'h10);
    wr(8'h3C, 8'h01);
    repeat (4) begin
      cyc(150);
      wr(8'h3F, 8'h55);
      wr(8'h3F, 8'h55);
      wr(8'h3F, 8'hAA);
    end
    req_is("refreshed", 1'b0);
    wr(8'h3F, 8'h12);
    req_is("bad key", 1'b1);
    do_reset;
    wr(8'h39, 8'h10);
    wr(8'h3C, 8'h81);
    cyc(200);
    wr(8'h3F, 8'h55);
    wr(8'h3F, 8'hAA);
    cyc(180);
    req_is("late refresh", 1'b0);
    wr(8'h3F, 8'h55);
    req_is("early refresh", 1'b1);
  endtask

  task automatic t_once;
    do_reset;
    wr(8'h3C, 8'h27);
    rd(8'h3C, 8'h00, "masked write");
    wr(8'h3C, 8'h02);
    wr(8'h3C, 8'h07);
    rd(8'h3C, 8'h02, "write once");
    wr(8'h3C, 8'h40);
    wr(8'h3C, 8'h00);
    rd(8'h3C, 8'h42, "halt set only");
    special_mode <= 1'b1;
    wr(8'h3C, 8'h03);
    rd(8'h3C, 8'h03, "special write");
  endtask

  task automatic t_debug;
    do_reset;
    special_mode <= 1'b1;
    debug_active <= 1'b1;
    wr(8'h39, 8'h10);
    wr(8'h3C, 8'h01);
    cyc(400);
    req_is("debug override", 1'b0);
    wr(8'h3C, 8'h41);
    cyc(400);
    req_is("halted in debug", 1'b0);
    debug_active <= 1'b0;
    rise_in(1'b0, 250, 262, "resume after debug");
  endtask

  task automatic t_flash;
    do_reset;
    flash_rate <= 3'h1;
    flash_window <= 1'b1;
    flash_load <= 1'b1;
    @(posedge ref_clk);
    flash_load <= 1'b0;
    rd(8'h3C, 8'h81, "flash load");
    rise_in(1'b0, 16370, 16392, "flash start");
  endtask

  // stop freezes the tick without clearing it; oscillator loss falls back to the rc source and restarts
  task automatic t_stop;
    do_reset;
    wr(8'h38, 8'h80);
    wr(8'h3B, 8'h10);
    stop_mode <= 1'b1;
    cyc(1100);
    #1;
    check("tick halted in stop", 8'h00, {7'h00, tick_irq});
    stop_mode <= 1'b0;
    rise_in(1'b1, 1014, 1034, "tick resumes after stop");
    wr(8'h37, 8'h80);
    osc_qualified <= 1'b1;
    osc_tick <= 1'b1;
    wr(8'h39, 8'h02);
    wr(8'h3B, 8'h10);
    cyc(500);
    osc_qualified <= 1'b0;
    rise_in(1'b1, 1016, 1036, "tick restart on osc loss");
    wr(8'h39, 8'h10);
    wr(8'h3C, 8'h01);
    stop_mode <= 1'b1;
    rise_in(1'b0, 250, 262, "aclk watchdog in stop");
    stop_mode <= 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // the whole sequence needs roughly 50k cycles
  initial begin
    #3000000;
    n_fail++;
    final_report;
  end

  initial begin
    t_regs;
    t_tick;
    t_wdog;
    t_refresh;
    t_once;
    t_debug;
    t_flash;
    t_stop;
    final_report;
  end
endmodule
